// [hdl/irq_summary_pkg.sv]
// Operation
// - summary bit 7 ORs every flag
// - bit 6 ORs group one, 4 group three
// - bit 5 ORs group two
// - bit 2 ORs group four; others read zero
// - summary reads a0 after reset
// - watchdog error event always sets group-one bit 7
// - wake timeout in sleep, local wake flags
// - groups one, three reset zero; reserved read zero
// - group three resets to zero
// - group-two bit 7 only on fault sleep entry
// - group two resets 40h, power-on flag set
// - group-two thermal, voltage flags at their bits
// - group-three bit 7 when serial status error sets
// - failsafe flag on entry, clearable while in failsafe
// - bit 4 check-sequence error, bit 3 regulator short
// - bit 2 when restart entries exceed limit
// - group-one mask resets to b0
// - limit field bits 7-4 allow 1-16 entries
package irq_summary_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_SUMMARY = 8'h50;
    localparam logic [7:0] IDX_WAKE_DOG = 8'h51;
    localparam logic [7:0] IDX_POWER_THERMAL = 8'h52;
    localparam logic [7:0] IDX_SERIAL_FAILSAFE = 8'h53;
    localparam logic [7:0] IDX_GROUP_FOUR = 8'h54;
    localparam logic [7:0] IDX_WAKE_DOG_MASK = 8'h56;
    localparam logic [7:0] IDX_WAKE_DOG_CLEAR = 8'h57;
    localparam logic [7:0] IDX_RESTART = 8'h28;
    // reset values
    localparam logic [7:0] RST_WAKE_DOG = 8'h00;
    localparam logic [7:0] RST_POWER_THERMAL = 8'h40;
    localparam logic [7:0] RST_SERIAL_FAILSAFE = 8'h00;
    localparam logic [7:0] RST_GROUP_FOUR = 8'h00;
    localparam logic [7:0] RST_WAKE_DOG_MASK = 8'hb0;
    localparam logic [3:0] RST_RESTART_SEL = 4'h4;
    localparam logic [7:0] RST_SUMMARY = 8'ha0;
    // implemented bits of each flag group
    localparam logic [7:0] VALID_WAKE_DOG = 8'hb0;
    localparam logic [7:0] VALID_POWER_THERMAL = 8'hf7;
    localparam logic [7:0] VALID_SERIAL_FAILSAFE = 8'hbc;
    localparam logic [7:0] VALID_GROUP_FOUR = 8'hff;
    // summary bit positions
    localparam int SUM_ANY = 7;
    localparam int SUM_G1 = 6;
    localparam int SUM_G2 = 5;
    localparam int SUM_G3 = 4;
    localparam int SUM_G4 = 2;
    // group one
    localparam int WATCHDOG_EVENT_FLAG = 7;
    localparam int LOCAL_WAKE_FLAG = 5;
    localparam int WAKE_TIMEOUT_FLAG = 4;
    // group two
    localparam int FAULT_SLEEP_FLAG = 7;
    localparam int POWER_ON_FLAG = 6;
    localparam int REGULATOR_OVER_VOLTAGE = 5;
    localparam int SUPPLY_UNDER_VOLTAGE = 4;
    localparam int REGULATOR_UNDER_VOLTAGE = 2;
    localparam int THERMAL_REGULATOR_TRANSCEIVER = 1;
    localparam int THERMAL_SWITCH_FALLBACK = 0;
    // group three
    localparam int SERIAL_STATUS_ERROR = 7;
    localparam int FAILSAFE_ENTRY_FLAG = 5;
    localparam int FRAME_CHECK_ERROR = 4;
    localparam int REGULATOR_SHORT_FLAG = 3;
    localparam int RESTART_LIMIT_FLAG = 2;
    // restart register fields
    localparam int RESTART_SEL_LSB = 4;
    localparam logic [4:0] RESTART_CNT_MAX = 5'h1f;
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // event sources, all on hclk
    typedef struct packed {
        logic watchdog_err;
        logic local_wake;
        logic sleep_wake_error_timer;
        logic in_sleep;
        logic sleep_entry;
        logic sleep_by_fault;
        logic reg_over_voltage;
        logic sup_under_voltage;
        logic reg_under_voltage;
        logic thermal_reg_xcvr;
        logic thermal_switch;
        logic serial_error_status;
        logic failsafe_active;
        logic frame_check_err;
        logic regulator_short;
        logic restart_entry;
        logic [7:0] group_four;
    } flag_events_s;
endpackage : irq_summary_pkg

// [hdl/irq_summary_ctrl.sv]
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// one byte of sticky flags; a set in the same cycle as a clear wins
module sticky_flag_byte #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] VALID = 8'hff
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] set_bits,
    input wire logic [7:0] clr_bits,
    output logic [7:0] flags
);
    logic [7:0] flags_ff;

    // reserved bits are masked so they can never become one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_ff <= RESET_VAL;
        end else begin
            flags_ff <= ((flags_ff & ~clr_bits) | set_bits) & VALID;
        end
    end

    assign flags = flags_ff;
endmodule : sticky_flag_byte

module irq_summary_ctrl (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire irq_summary_pkg::flag_events_s events,
    output logic irq
);
    import irq_summary_pkg::*;

    logic addr_phase;
    logic [7:0] addr_idx;
    logic wr_pend_ff;
    logic [7:0] wr_idx_ff;
    logic [7:0] wdata;
    logic [7:0] g1;
    logic [7:0] g2;
    logic [7:0] g3;
    logic [7:0] g4;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] set3;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [7:0] clr3;
    logic [7:0] clr4;
    logic [7:0] summary;
    logic [7:0] mask1_ff;
    logic [3:0] restart_sel_ff;
    logic [4:0] restart_cnt_ff;
    logic [4:0] nxt_restart_cnt;
    logic [3:0] restart_cnt_rd;
    logic restart_clr;
    logic serial_prev_ff;
    logic failsafe_prev_ff;
    logic [7:0] rd_val;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic irq_ff;

    // address phase decode; hsize is not checked since only words are used
    assign addr_phase = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign addr_idx = haddr[9:2];
    assign wdata = hwdata[7:0];

    // the write lands in the data phase, one cycle after the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase && hwrite && (haddr[31:10] == 22'h0);
            wr_idx_ff <= addr_idx;
        end
    end

    // write-one-to-clear strobes; the clear register is a second path to group one
    assign clr1 = (wr_pend_ff && (wr_idx_ff == IDX_WAKE_DOG || wr_idx_ff == IDX_WAKE_DOG_CLEAR)) ? wdata : 8'h00;
    assign clr2 = (wr_pend_ff && wr_idx_ff == IDX_POWER_THERMAL) ? wdata : 8'h00;
    assign clr3 = (wr_pend_ff && wr_idx_ff == IDX_SERIAL_FAILSAFE) ? wdata : 8'h00;
    assign clr4 = (wr_pend_ff && wr_idx_ff == IDX_GROUP_FOUR) ? wdata : 8'h00;
    assign restart_clr = wr_pend_ff && (wr_idx_ff == IDX_RESTART) && (wdata[3:0] != 4'h0);

    // group one set terms
    always_comb begin
        set1 = 8'h00;
        set1[WATCHDOG_EVENT_FLAG] = events.watchdog_err;
        set1[LOCAL_WAKE_FLAG] = events.local_wake;
        set1[WAKE_TIMEOUT_FLAG] = events.sleep_wake_error_timer && events.in_sleep;
    end

    // group two set terms; a normal sleep entry leaves the fault-sleep flag alone
    always_comb begin
        set2 = 8'h00;
        set2[FAULT_SLEEP_FLAG] = events.sleep_entry && events.sleep_by_fault;
        set2[REGULATOR_OVER_VOLTAGE] = events.reg_over_voltage;
        set2[SUPPLY_UNDER_VOLTAGE] = events.sup_under_voltage;
        set2[REGULATOR_UNDER_VOLTAGE] = events.reg_under_voltage;
        set2[THERMAL_REGULATOR_TRANSCEIVER] = events.thermal_reg_xcvr;
        set2[THERMAL_SWITCH_FALLBACK] = events.thermal_switch;
    end

    // group three set terms; level sources are edge-detected so a clear sticks
    always_comb begin
        set3 = 8'h00;
        set3[SERIAL_STATUS_ERROR] = events.serial_error_status && !serial_prev_ff;
        set3[FAILSAFE_ENTRY_FLAG] = events.failsafe_active && !failsafe_prev_ff;
        set3[FRAME_CHECK_ERROR] = events.frame_check_err;
        set3[REGULATOR_SHORT_FLAG] = events.regulator_short;
        set3[RESTART_LIMIT_FLAG] = events.restart_entry && (restart_cnt_ff > {1'b0, restart_sel_ff});
    end

    // previous levels for the two edge detectors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_prev_ff <= 1'b0;
            failsafe_prev_ff <= 1'b0;
        end else begin
            serial_prev_ff <= events.serial_error_status;
            failsafe_prev_ff <= events.failsafe_active;
        end
    end

    // flag groups
    sticky_flag_byte #(.RESET_VAL(RST_WAKE_DOG), .VALID(VALID_WAKE_DOG)) u_group_one (
        .hclk(hclk), .hresetn(hresetn), .set_bits(set1), .clr_bits(clr1), .flags(g1)
    );
    sticky_flag_byte #(.RESET_VAL(RST_POWER_THERMAL), .VALID(VALID_POWER_THERMAL)) u_group_two (
        .hclk(hclk), .hresetn(hresetn), .set_bits(set2), .clr_bits(clr2), .flags(g2)
    );
    sticky_flag_byte #(.RESET_VAL(RST_SERIAL_FAILSAFE), .VALID(VALID_SERIAL_FAILSAFE)) u_group_three (
        .hclk(hclk), .hresetn(hresetn), .set_bits(set3), .clr_bits(clr3), .flags(g3)
    );
    sticky_flag_byte #(.RESET_VAL(RST_GROUP_FOUR), .VALID(VALID_GROUP_FOUR)) u_group_four (
        .hclk(hclk), .hresetn(hresetn), .set_bits(events.group_four), .clr_bits(clr4), .flags(g4)
    );

    // restart counter: saturates so a long run never wraps back under the limit
    always_comb begin
        nxt_restart_cnt = restart_clr ? 5'h00 : restart_cnt_ff;
        if (events.restart_entry && nxt_restart_cnt != RESTART_CNT_MAX) begin
            nxt_restart_cnt = nxt_restart_cnt + 5'h01;
        end
    end

    // limit field and entry count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_sel_ff <= RST_RESTART_SEL;
            restart_cnt_ff <= 5'h00;
        end else begin
            restart_cnt_ff <= nxt_restart_cnt;
            if (wr_pend_ff && wr_idx_ff == IDX_RESTART) begin
                restart_sel_ff <= wdata[7:RESTART_SEL_LSB];
            end
        end
    end

    assign restart_cnt_rd = restart_cnt_ff[4] ? 4'hf : restart_cnt_ff[3:0];

    // group-one mask, also the interrupt enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask1_ff <= RST_WAKE_DOG_MASK;
        end else if (wr_pend_ff && wr_idx_ff == IDX_WAKE_DOG_MASK) begin
            mask1_ff <= wdata & VALID_WAKE_DOG;
        end
    end

    // summary is pure hardware; no write path reaches it
    always_comb begin
        summary = 8'h00;
        summary[SUM_ANY] = |{g1, g2, g3, g4};
        summary[SUM_G1] = |g1;
        summary[SUM_G2] = |g2;
        summary[SUM_G3] = |g3;
        summary[SUM_G4] = |g4;
    end

    // read mux; unmapped and write-only indices read zero
    always_comb begin
        case (addr_idx)
            IDX_SUMMARY: rd_val = summary;
            IDX_WAKE_DOG: rd_val = g1;
            IDX_POWER_THERMAL: rd_val = g2;
            IDX_SERIAL_FAILSAFE: rd_val = g3;
            IDX_GROUP_FOUR: rd_val = g4;
            IDX_WAKE_DOG_MASK: rd_val = mask1_ff;
            IDX_RESTART: rd_val = {restart_sel_ff, restart_cnt_rd};
            default: rd_val = 8'h00;
        endcase
    end

    // read data is captured at the address phase so the data phase needs no wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= HRESP_OKAY;
        end else begin
            hrdata_ff <= (addr_phase && !hwrite && haddr[31:10] == 22'h0) ? {24'h0, rd_val} : 32'h0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= HRESP_OKAY;
        end
    end

    // interrupt output, one cycle behind the flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(g1 & mask1_ff);
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign irq = irq_ff;

    // helper: low only in the first cycle after reset release
    logic boot_ff;
    logic rd_sum;
    logic wr_sum;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_ff <= 1'b0;
        end else begin
            boot_ff <= 1'b1;
        end
    end
    assign rd_sum = addr_phase && !hwrite && addr_idx == IDX_SUMMARY && haddr[31:10] == 22'h0;
    assign wr_sum = wr_pend_ff && wr_idx_ff == IDX_SUMMARY;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sum_global_a: assert property (rd_sum |=> hrdata[7] == $past(|{g1, g2, g3, g4}))
        else $error("summary bit 7 is not the OR of all flags");
    sum_groups_a: assert property (rd_sum |=> hrdata[6] == $past(|g1) && hrdata[4] == $past(|g3))
        else $error("summary group one or three bit wrong");
    sum_grp2_a: assert property (rd_sum |=> hrdata[5] == $past(|g2))
        else $error("summary group two bit wrong");
    sum_rsvd_a: assert property (rd_sum |=> hrdata[2] == $past(|g4) && hrdata[3] == 1'b0 && hrdata[1:0] == 2'h0)
        else $error("summary group four or reserved bits wrong");
    reset_sum_a: assert property (!boot_ff |-> summary == RST_SUMMARY && mask1_ff == RST_WAKE_DOG_MASK)
        else $error("summary or mask reset value wrong");
    watchdog_set_a: assert property (events.watchdog_err |=> g1[WATCHDOG_EVENT_FLAG])
        else $error("watchdog event did not set flag");
    wake_set_a: assert property (events.sleep_wake_error_timer && events.in_sleep |=> g1[WAKE_TIMEOUT_FLAG])
        else $error("wake timeout did not set flag");
    rsvd_zero_a: assert property ((g1 & ~VALID_WAKE_DOG) == 8'h00 && (g3 & ~VALID_SERIAL_FAILSAFE) == 8'h00)
        else $error("reserved flag bit set");
    init_zero_a: assert property (!boot_ff |-> g1 == 8'h00 && g3 == 8'h00 && g2 == RST_POWER_THERMAL)
        else $error("flag group reset value wrong");
    normal_sleep_a: assert property (!g2[FAULT_SLEEP_FLAG] && !events.sleep_by_fault |=> !g2[FAULT_SLEEP_FLAG])
        else $error("fault sleep flag set without fault");
    power_hold_a: assert property (g2[POWER_ON_FLAG] && !clr2[POWER_ON_FLAG] |=> g2[POWER_ON_FLAG])
        else $error("power-on flag lost without a clear");
    therm_set_a: assert property (events.thermal_reg_xcvr && events.reg_under_voltage |=>
        g2[THERMAL_REGULATOR_TRANSCEIVER] && g2[REGULATOR_UNDER_VOLTAGE])
        else $error("group two event did not set its flag");
    serial_edge_a: assert property ($rose(events.serial_error_status) |=> g3[SERIAL_STATUS_ERROR])
        else $error("serial status error did not set flag");
    fs_clear_a: assert property (clr3[FAILSAFE_ENTRY_FLAG] && events.failsafe_active && failsafe_prev_ff
        |=> !g3[FAILSAFE_ENTRY_FLAG])
        else $error("failsafe flag not cleared while in failsafe");
    check_set_a: assert property (events.frame_check_err && events.regulator_short |=>
        g3[FRAME_CHECK_ERROR] && g3[REGULATOR_SHORT_FLAG])
        else $error("check error or short did not set flag");
    restart_lim_a: assert property (events.restart_entry && restart_cnt_ff > {1'b0, restart_sel_ff}
        |=> g3[RESTART_LIMIT_FLAG])
        else $error("restart limit not flagged");
    restart_ok_a: assert property (!g3[RESTART_LIMIT_FLAG] && restart_cnt_ff <= {1'b0, restart_sel_ff}
        |=> !g3[RESTART_LIMIT_FLAG])
        else $error("restart limit flagged early");
    mask_irq_a: assert property (mask1_ff == RST_WAKE_DOG_MASK && g1[WATCHDOG_EVENT_FLAG] |=> irq)
        else $error("enabled flag did not raise interrupt");
    sum_ro_a: assert property (wr_sum && set1 == 8'h00 && set2 == 8'h00 |=> g1 == $past(g1) && g2 == $past(g2))
        else $error("summary write disturbed flags");
    set_wins_a: assert property (events.watchdog_err && clr1[WATCHDOG_EVENT_FLAG] |=> g1[WATCHDOG_EVENT_FLAG])
        else $error("clear beat a same-cycle set");
endmodule : irq_summary_ctrl

// [test/test_irq_summary_ctrl.sv]
`timescale 1ns/1ps
module test_irq_summary_ctrl;
    import irq_summary_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    flag_events_s ev = '0;
    flag_events_s m;
    int error_cnt = 0;
    int num_checks = 0;

    irq_summary_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .events(ev), .irq(irq));

    // 125 mhz clock
    always #4 hclk = ~hclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one single transfer; address phase held until hready, data phase likewise
    task automatic xfer(input logic is_wr, input logic [7:0] idx, input logic [31:0] wdat, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= is_wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdat;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] wdat);
        logic [31:0] dummy;
        xfer(1'b1, idx, wdat, dummy);
    endtask : wr

    task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        xfer(1'b0, idx, 32'h0, d);
        check(d, {24'h0, exp});
    endtask : rd_check

    // event pulse of one cycle; levels already held in ev survive it
    task automatic pulse(input flag_events_s p);
        @(posedge hclk);
        ev <= ev | p;
        @(posedge hclk);
        ev <= ev & ~p;
    endtask : pulse

    task automatic test_reset_values;
        rd_check(IDX_SUMMARY, 8'ha0);
        rd_check(IDX_WAKE_DOG, 8'h00);
        rd_check(IDX_POWER_THERMAL, 8'h40);
        rd_check(IDX_SERIAL_FAILSAFE, 8'h00);
        rd_check(IDX_WAKE_DOG_MASK, 8'hb0);
        rd_check(IDX_RESTART, 8'h40);
        check({31'h0, irq}, 32'h0);
    endtask : test_reset_values

    // watchdog flag, mask and irq path, wake flags, clear alias
    task automatic test_group_one;
        m = '0; m.watchdog_err = 1'b1; pulse(m);
        rd_check(IDX_WAKE_DOG, 8'h80);
        check({31'h0, irq}, 32'h1);
        rd_check(IDX_SUMMARY, 8'he0);
        wr(IDX_WAKE_DOG, 32'h0);
        rd_check(IDX_WAKE_DOG, 8'h80);
        wr(IDX_WAKE_DOG_MASK, 32'hffffffff);
        rd_check(IDX_WAKE_DOG_MASK, 8'hb0);
        wr(IDX_WAKE_DOG_MASK, 32'h0);
        rd_check(IDX_WAKE_DOG_MASK, 8'h00);
        check({31'h0, irq}, 32'h0);
        wr(IDX_WAKE_DOG_MASK, 32'hb0);
        rd_check(IDX_WAKE_DOG, 8'h80);
        check({31'h0, irq}, 32'h1);
        wr(IDX_WAKE_DOG, 32'h80);
        rd_check(IDX_WAKE_DOG, 8'h00);
        check({31'h0, irq}, 32'h0);
        m = '0; m.sleep_wake_error_timer = 1'b1; pulse(m);
        rd_check(IDX_WAKE_DOG, 8'h00);
        m.in_sleep = 1'b1; pulse(m);
        rd_check(IDX_WAKE_DOG, 8'h10);
        m = '0; m.local_wake = 1'b1; pulse(m);
        rd_check(IDX_WAKE_DOG, 8'h30);
        rd_check(IDX_SUMMARY, 8'he0);
        wr(IDX_WAKE_DOG_CLEAR, 32'h30);
        rd_check(IDX_WAKE_DOG, 8'h00);
        rd_check(IDX_WAKE_DOG_CLEAR, 8'h00);
    endtask : test_group_one

    // fault sleep only on fault, every voltage and thermal flag at its bit
    task automatic test_group_two;
        wr(IDX_POWER_THERMAL, 32'h40);
        rd_check(IDX_POWER_THERMAL, 8'h00);
        rd_check(IDX_SUMMARY, 8'h00);
        m = '0; m.sleep_entry = 1'b1; pulse(m);
        rd_check(IDX_POWER_THERMAL, 8'h00);
        m.sleep_by_fault = 1'b1; pulse(m);
        rd_check(IDX_POWER_THERMAL, 8'h80);
        m = '0; m.reg_over_voltage = 1'b1; pulse(m);
        rd_check(IDX_POWER_THERMAL, 8'ha0);
        m = '0; m.sup_under_voltage = 1'b1; m.reg_under_voltage = 1'b1; pulse(m);
        rd_check(IDX_POWER_THERMAL, 8'hb4);
        m = '0; m.thermal_reg_xcvr = 1'b1; m.thermal_switch = 1'b1; pulse(m);
        rd_check(IDX_POWER_THERMAL, 8'hb7);
        rd_check(IDX_SUMMARY, 8'ha0);
        wr(IDX_POWER_THERMAL, 32'hff);
        rd_check(IDX_POWER_THERMAL, 8'h00);
    endtask : test_group_two

    // serial error and failsafe on rising levels; failsafe clear sticks while held
    task automatic test_group_three;
        @(posedge hclk);
        ev.serial_error_status <= 1'b1;
        ev.failsafe_active <= 1'b1;
        rd_check(IDX_SERIAL_FAILSAFE, 8'ha0);
        wr(IDX_SERIAL_FAILSAFE, 32'h20);
        rd_check(IDX_SERIAL_FAILSAFE, 8'h80);
        m = '0; m.frame_check_err = 1'b1; m.regulator_short = 1'b1; pulse(m);
        rd_check(IDX_SERIAL_FAILSAFE, 8'h98);
        rd_check(IDX_SUMMARY, 8'h90);
        @(posedge hclk);
        ev.serial_error_status <= 1'b0;
        ev.failsafe_active <= 1'b0;
        wr(IDX_SERIAL_FAILSAFE, 32'hff);
        rd_check(IDX_SERIAL_FAILSAFE, 8'h00);
    endtask : test_group_three

    task automatic test_group_four;
        m = '0; m.group_four = 8'h81; pulse(m);
        rd_check(IDX_SUMMARY, 8'h84);
        wr(IDX_GROUP_FOUR, 32'hff);
        rd_check(IDX_SUMMARY, 8'h00);
    endtask : test_group_four

    // limit select 0 allows one entry; the second entry raises the flag
    task automatic test_restart_limit;
        wr(IDX_RESTART, 32'h0f);
        rd_check(IDX_RESTART, 8'h00);
        m = '0; m.restart_entry = 1'b1; pulse(m);
        rd_check(IDX_SERIAL_FAILSAFE, 8'h00);
        pulse(m);
        rd_check(IDX_SERIAL_FAILSAFE, 8'h04);
        rd_check(IDX_RESTART, 8'h02);
        rd_check(IDX_SUMMARY, 8'h90);
        wr(IDX_SERIAL_FAILSAFE, 32'h04);
        wr(IDX_RESTART, 32'h51);
        rd_check(IDX_RESTART, 8'h50);
    endtask : test_restart_limit

    // summary ignores writes even with a flag standing; unmapped place reads zero
    task automatic test_read_only;
        m = '0; m.watchdog_err = 1'b1; pulse(m);
        wr(IDX_SUMMARY, 32'hff);
        rd_check(IDX_SUMMARY, 8'hc0);
        rd_check(IDX_WAKE_DOG, 8'h80);
        wr(IDX_WAKE_DOG, 32'h80);
        rd_check(IDX_SUMMARY, 8'h00);
        wr(8'h55, 32'hff);
        rd_check(8'h55, 8'h00);
    endtask : test_read_only

    // a reset in mid-run must bring flags, mask, restart field and irq back
    task automatic test_mid_reset;
        m = '0; m.watchdog_err = 1'b1; m.frame_check_err = 1'b1; pulse(m);
        rd_check(IDX_SERIAL_FAILSAFE, 8'h10);
        check({31'h0, irq}, 32'h1);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset_values();
    endtask : test_mid_reset

    task automatic report_and_stop;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset_values();
        test_group_one();
        test_group_two();
        test_group_three();
        test_group_four();
        test_restart_limit();
        test_read_only();
        test_mid_reset();
        report_and_stop();
    end

    // watchdog; the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        report_and_stop();
    end
endmodule : test_irq_summary_ctrl
